/* File: power_up_sequencer_tb.sv */
// Self-checking testbench for the power-up sequencer.
`timescale 1ns/100ps
module power_up_sequencer_tb;
   import pus_pkg::*;
   // Bench-driven levels; supply status sits in one vector by position.
   logic               core_clk = 1'b0;
   logic               rstn     = 1'b0;
   logic [SY_W-1:0]    sy       = '0;
   logic [START_W-1:0] starts   = '0;
   logic host_up = 1'b0, spi_rst_req = 1'b0, gate_req = 1'b0, mc_req = 1'b0;
   logic ext_n, spi_n, gate_cmd, mc_en;
   // Design outputs; obs packs the status levels.
   logic bg, dac, core, cp, pll, gate, boost, por_n, crst_n;
   logic ioen, iordy, mcr, pred;
   logic [START_W-1:0] starts_out;
   logic [12:0]        obs;
   // Expected results queued by the driver, consumed by the monitor.
   typedef struct {logic kind; logic [12:0] exp; logic [12:0] mask;} pus_note_t;
   pus_note_t notes[$];
   pus_note_t note;
   logic chk_req = 1'b0;
   int   errors = 0;
   int   num_checks = 0;
   int   i;
   assign obs = {bg, dac, core, por_n, crst_n, cp, pll, ioen, iordy, gate,
                 mcr, boost, pred};

   // Free-running 50 MHz clock.
   always #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;

   pus_sequencer uut (.core_clk(core_clk), .rstn(rstn),
      .vcc5_ok(sy[SY_VCC5]), .bandgap_stable(sy[SY_BANDGAP]),
      .dac_reference_stable(sy[SY_DAC_REF]), .core_supply_ok(sy[SY_CORE]),
      .boost_supply_ok(sy[SY_BOOST]), .io_supply_ok(sy[SY_IO]),
      .logic_supply_ok(sy[SY_LOGIC]), .charge_pump_ok(sy[SY_PUMP]),
      .gate_supply_external(sy[SY_GATE_EXT]), .clk_in_stable(sy[SY_CLK_IN]),
      .pll_locked(sy[SY_PLL]), .external_reset_n(ext_n),
      .actuation_start_inputs(starts), .spi_reset_n(spi_n),
      .spi_gate_reg_enable(gate_cmd), .microcore_enable(mc_en),
      .bandgap_en(bg), .dac_reference_en(dac), .core_reg_en(core),
      .charge_pump_en(cp), .pll_en(pll), .gate_supply_reg_en(gate),
      .boost_en(boost), .power_on_reset_n(por_n), .core_reset_n(crst_n),
      .io_enable(ioen), .io_ready(iordy), .microcore_run(mcr),
      .predriver_enable(pred), .actuation_start_out(starts_out));

   pus_host_model u_host (.core_clk(core_clk), .rstn(rstn),
      .pll_locked(sy[SY_PLL]), .power_on_reset_n(por_n), .io_ready(iordy),
      .host_up(host_up), .spi_rst_req(spi_rst_req), .gate_req(gate_req),
      .mc_req(mc_req), .external_reset_n(ext_n), .spi_reset_n(spi_n),
      .spi_gate_reg_enable(gate_cmd), .microcore_enable(mc_en));

   // Prints the counts and the verdict, then stops the run.
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   // Queues a note; two edges pass so the strobe is never set twice at once.
   task automatic expect_out(input logic k, input logic [12:0] e,
                             input logic [12:0] m);
      notes.push_back('{k, e, m});
      chk_req <= 1'b1;
      @(posedge core_clk);
      chk_req <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic cmp_status(input logic [12:0] e, input logic [12:0] m);
      num_checks++;
      if ((obs & m) !== (e & m))
      begin
         errors++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, e & m, obs & m);
      end
   endtask

   task automatic cmp_starts(input logic [START_W-1:0] e);
      num_checks++;
      if (starts_out !== e)
      begin
         errors++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, e, starts_out);
      end
   endtask

   // Monitor: outputs are settled by the falling edge.
   always @(negedge core_clk)
   begin
      if (chk_req === 1'b1 && notes.size() > 0)
      begin
         note = notes.pop_front();
         if (note.kind)
            cmp_starts(note.exp[START_W-1:0]);
         else
            cmp_status(note.exp, note.mask);
      end
   end

   // Watchdog sized well beyond the whole sequence.
   initial
   begin
      wait_cyc(20000);
      errors++;
      $display("timeout t=%0t", $time);
      close_out();
   end

   initial
   begin
      void'($urandom(39));
      @(posedge core_clk);
      starts <= START_W'($urandom);
      expect_out(1'b0, 13'h0000, 13'h1FFF);
      expect_out(1'b1, 13'h0000, 13'h1FFF);
      rstn <= 1'b1;
      $display("test reset done");
      // Stage walk one condition at a time; boost and clock arrive early.
      sy[SY_VCC5] <= 1'b1;
      wait_cyc(8);
      expect_out(1'b0, 13'h1000, 13'h1E00);
      sy[SY_BANDGAP] <= 1'b1;
      wait_cyc(8);
      expect_out(1'b0, 13'h1800, 13'h1E00);
      sy[SY_DAC_REF] <= 1'b1;
      sy[SY_BOOST] <= 1'b1;
      sy[SY_CLK_IN] <= 1'b1;
      wait_cyc(8);
      expect_out(1'b0, 13'h1C00, 13'h1EC0);
      sy[SY_CORE] <= 1'b1;
      wait_cyc(POR_FILTER_CYC);
      expect_out(1'b0, 13'h0000, 13'h0200);
      wait_cyc(10);
      expect_out(1'b0, 13'h0280, 13'h03E0);
      sy[SY_IO] <= 1'b1;
      sy[SY_LOGIC] <= 1'b1;
      wait_cyc(8);
      expect_out(1'b0, 13'h0060, 13'h0070);
      wait_cyc(DIO_READY_CYC + 10);
      expect_out(1'b0, 13'h0010, 13'h0010);
      sy[SY_PLL] <= 1'b1;
      host_up <= 1'b1;
      wait_cyc(10);
      expect_out(1'b0, 13'h0100, 13'h0100);
      $display("test power-up walk done");
      // Gate regulator: pump missing, then present, then external supply.
      gate_req <= 1'b1;
      wait_cyc(3);
      gate_req <= 1'b0;
      wait_cyc(8);
      expect_out(1'b0, 13'h0000, 13'h0008);
      sy[SY_PUMP] <= 1'b1;
      wait_cyc(8);
      expect_out(1'b0, 13'h0008, 13'h0008);
      sy[SY_GATE_EXT] <= 1'b1;
      wait_cyc(8);
      expect_out(1'b0, 13'h0000, 13'h0008);
      sy[SY_GATE_EXT] <= 1'b0;
      wait_cyc(8);
      expect_out(1'b0, 13'h0008, 13'h0008);
      $display("test gate regulator done");
      // Starts are blocked until the microcores run, then follow the pins.
      starts <= START_W'($urandom) | 6'h01;
      wait_cyc(3);
      expect_out(1'b1, 13'h0000, 13'h1FFF);
      mc_req <= 1'b1;
      wait_cyc(8);
      expect_out(1'b0, 13'h0007, 13'h0007);
      for (i = 0; i < 8; i++)
      begin
         starts <= (i < START_W) ? START_W'(1 << i) : START_W'($urandom);
         wait_cyc(6);
         expect_out(1'b1, 13'(starts), 13'h1FFF);
      end
      $display("test actuation done");
      // SPI reset drops core reset and all drive, and clears the request.
      spi_rst_req <= 1'b1;
      wait_cyc(8);
      expect_out(1'b0, 13'h0200, 13'h030F);
      expect_out(1'b1, 13'h0000, 13'h1FFF);
      spi_rst_req <= 1'b0;
      wait_cyc(10);
      expect_out(1'b0, 13'h0100, 13'h0108);
      // Core supply loss re-asserts power-on reset.
      sy[SY_CORE] <= 1'b0;
      wait_cyc(8);
      expect_out(1'b0, 13'h0400, 13'h0704);
      sy[SY_CORE] <= 1'b1;
      wait_cyc(30);
      expect_out(1'b0, 13'h0200, 13'h0200);
      $display("test reset sources done");
      // Power-down: no actuation, reset pin low, then supplies removed.
      starts <= '0;
      mc_req <= 1'b0;
      wait_cyc(4);
      host_up <= 1'b0;
      wait_cyc(8);
      expect_out(1'b0, 13'h0000, 13'h0100);
      sy <= '0;
      wait_cyc(8);
      expect_out(1'b0, 13'h0000, 13'h1FFF);
      $display("test power-down done");
      // Supplies return in reverse order with random gaps.
      for (i = SY_W - 1; i >= 0; i--)
      begin
         if (i != SY_EXT_RST && i != SY_GATE_EXT)
            sy[i] <= 1'b1;
         wait_cyc(1 + ($urandom % 20));
      end
      host_up <= 1'b1;
      wait_cyc(DIO_READY_CYC + POR_FILTER_CYC + 40);
      expect_out(1'b0, 13'h1FF0, 13'h1FF0);
      $display("test supply order done");
      close_out();
   end
endmodule // power_up_sequencer_tb

/* File: pus_host_model.sv */
// Host microcontroller model driving the reset pin and SPI commands.
`timescale 1ns/100ps
module pus_host_model (
   // Clock and reset.
   input  wire logic core_clk,
   input  wire logic rstn,
   // Device status seen by the host.
   input  wire logic pll_locked,
   input  wire logic power_on_reset_n,
   input  wire logic io_ready,
   // Requests from the bench.
   input  wire logic host_up,
   input  wire logic spi_rst_req,
   input  wire logic gate_req,
   input  wire logic mc_req,
   // Reset pin and SPI command levels.
   output logic      external_reset_n,
   output logic      spi_reset_n,
   output logic      spi_gate_reg_enable,
   output logic      microcore_enable
);
   // Gate and microcore commands are only sent once the device is out of reset and ready.
   logic cfg_ok;
   assign cfg_ok = power_on_reset_n & io_ready & external_reset_n;

   // Every host output changes just after a rising edge.
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         external_reset_n    <= 1'b0;
         spi_reset_n         <= 1'b1;
         spi_gate_reg_enable <= 1'b0;
         microcore_enable    <= 1'b0;
      end
      else
      begin
         // Pin is released after lock and pulled low first at power-down.
         external_reset_n    <= host_up & pll_locked;
         spi_reset_n         <= ~spi_rst_req;
         spi_gate_reg_enable <= gate_req & cfg_ok;
         microcore_enable    <= mc_req & cfg_ok;
      end
   end
endmodule // pus_host_model

/* File: pus_pkg.sv */
// Constants and types shared by the power-up sequencer files.
package pus_pkg;

   // Core clock period in nanoseconds (50 MHz).
   localparam int CLK_PERIOD_NS = 20;

   // Least time the core supply must stay good before reset is released.
   localparam int POR_FILTER_NS = 361;
   // Cycles for that filter, rounded up; zero if the filter time is zero.
   localparam int POR_FILTER_CYC =
      (POR_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Digital I/O ready time after power-on reset release (plain default).
   localparam int DIO_READY_NS = 1000;
   // Cycles for the I/O ready time, rounded up.
   localparam int DIO_READY_CYC =
      (DIO_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Width of the timing counters.
   localparam int CNT_W = 16;

   // Number of actuation start inputs.
   localparam int START_W = 6;

   // Positions of the pin-side status levels in the qualifier vector.
   localparam int SY_VCC5      = 0;
   localparam int SY_BANDGAP   = 1;
   localparam int SY_DAC_REF   = 2;
   localparam int SY_CORE      = 3;
   localparam int SY_BOOST     = 4;
   localparam int SY_IO        = 5;
   localparam int SY_LOGIC     = 6;
   localparam int SY_CLK_IN    = 7;
   localparam int SY_PLL       = 8;
   localparam int SY_EXT_RST   = 9;
   localparam int SY_PUMP      = 10;
   localparam int SY_GATE_EXT  = 11;
   localparam int SY_W         = 12;

   // Power-up stages of the reference and core supply chain.
   typedef enum logic [2:0] {
      PUS_OFF,
      PUS_BANDGAP,
      PUS_DAC_REF,
      PUS_CORE_REG,
      PUS_POR_HOLD,
      PUS_READY
   } pus_stage_t;

endpackage : pus_pkg

/* File: pus_qualify.sv */
// Four-flop input qualifier for levels arriving from outside the clock.
`timescale 1ns/100ps
module pus_qualify #(
   parameter int W = 1
) (
   // Clock and reset.
   input  wire logic         core_clk,
   input  wire logic         rstn,
   // Raw levels and qualified levels.
   input  wire logic [W-1:0] raw_in,
   output logic      [W-1:0] qual_out
);
   import pus_pkg::*;

   // All flops of the qualifier in one record.
   typedef struct packed {
      logic [W-1:0] s1;   // First stage, read only by the second.
      logic [W-1:0] s2;   // Second stage.
      logic [W-1:0] s3;   // Third stage.
      logic [W-1:0] q;    // Qualified level.
   } pus_qual_t;

   pus_qual_t st_reg;    // Registered state.
   pus_qual_t st_next;   // Next state.

   // A bit changes only once the second and third stages agree, so a
   // single-cycle glitch past the first stage never reaches the core.
   always_comb
   begin
      st_next    = st_reg;
      st_next.s1 = raw_in;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      st_next.q  = (st_reg.s2 & st_reg.s3) |
                   (st_reg.q & (st_reg.s2 | st_reg.s3));
   end

   // Registers clear to zero, so every level reads as absent at reset.
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign qual_out = st_reg.q;

endmodule // pus_qualify

/* File: pus_sequencer.sv */
// Power-up sequencer: supply stages, resets, pump, PLL and drive gating.
//
// Function
// - Start bandgap, DAC reference, core regulator in order.
// - Hold power-on reset until core supply good.
// - Start charge pump after reset release, boost present.
// - Use digital pins only with I/O, logic supplies.
// - Start PLL once stable input clock present.
// - Gate regulator off after reset, SPI enables.
// - Gate regulator needs running charge pump.
// - Microcores start boost, then actuation follows starts.
// - Any supply order or ramp starts correctly.
// - Core reset is AND of three resets.
`timescale 1ns/100ps
module pus_sequencer (
   // Clock and reset.
   input  wire logic                        core_clk,
   input  wire logic                        rstn,
   // Supply and reference status levels from the analog monitors.
   input  wire logic                        vcc5_ok,
   input  wire logic                        bandgap_stable,
   input  wire logic                        dac_reference_stable,
   input  wire logic                        core_supply_ok,
   input  wire logic                        boost_supply_ok,
   input  wire logic                        io_supply_ok,
   input  wire logic                        logic_supply_ok,
   input  wire logic                        charge_pump_ok,
   input  wire logic                        gate_supply_external,
   // Clock input and PLL status.
   input  wire logic                        clk_in_stable,
   input  wire logic                        pll_locked,
   // Host pins.
   input  wire logic                        external_reset_n,
   input  wire logic [pus_pkg::START_W-1:0] actuation_start_inputs,
   // Commands from the SPI logic on this clock.
   input  wire logic                        spi_reset_n,
   input  wire logic                        spi_gate_reg_enable,
   input  wire logic                        microcore_enable,
   // Analog enables.
   output logic                             bandgap_en,
   output logic                             dac_reference_en,
   output logic                             core_reg_en,
   output logic                             charge_pump_en,
   output logic                             pll_en,
   output logic                             gate_supply_reg_en,
   output logic                             boost_en,
   // Resets and readiness.
   output logic                             power_on_reset_n,
   output logic                             core_reset_n,
   output logic                             io_enable,
   output logic                             io_ready,
   // Drive side.
   output logic                             microcore_run,
   output logic                             predriver_enable,
   output logic [pus_pkg::START_W-1:0]      actuation_start_out
);
   import pus_pkg::*;

   // Whole sequencer state in one record.
   typedef struct packed {
      pus_stage_t         stage;      // Reference chain stage.
      logic [CNT_W-1:0]   por_cnt;    // Core supply good filter.
      logic [CNT_W-1:0]   dio_cnt;    // Digital I/O ready timer.
      logic               bg_en;      // Bandgap enable.
      logic               dac_en;     // DAC reference enable.
      logic               core_en;    // Core regulator enable.
      logic               por_n;      // Power-on reset, low active.
      logic               rst_n;      // Core reset, low active.
      logic               io_en;      // Digital pads usable.
      logic               io_rdy;     // I/O ready time elapsed.
      logic               cp_en;      // Charge pump enable.
      logic               pll;        // PLL enable.
      logic               gate_cmd;   // Gate regulator request held.
      logic               gate_en;    // Gate regulator running.
      logic               mc;         // Microcores running.
      logic               boost;      // Boost converter enable.
      logic               drv;        // Pre-drivers enabled.
      logic [START_W-1:0] starts;     // Gated start requests.
   } pus_seq_t;

   pus_seq_t          st_reg;   // Registered state.
   pus_seq_t          st_next;  // Next state.
   localparam int     QW = SY_W + START_W;  // Status levels plus start pins.
   logic [QW-1:0]     raw_lv;   // Pin-side levels before qualifying.
   logic [QW-1:0]     lv;       // Qualified levels.
   logic              pads_on;  // I/O and logic supplies present.
   logic              ext_rst;  // External reset seen through the pads.

   // Every pin-side level crosses in through the qualifier.
   assign raw_lv[SY_VCC5]     = vcc5_ok;
   assign raw_lv[SY_BANDGAP]  = bandgap_stable;
   assign raw_lv[SY_DAC_REF]  = dac_reference_stable;
   assign raw_lv[SY_CORE]     = core_supply_ok;
   assign raw_lv[SY_BOOST]    = boost_supply_ok;
   assign raw_lv[SY_IO]       = io_supply_ok;
   assign raw_lv[SY_LOGIC]    = logic_supply_ok;
   assign raw_lv[SY_CLK_IN]   = clk_in_stable;
   assign raw_lv[SY_PLL]      = pll_locked;
   assign raw_lv[SY_EXT_RST]  = external_reset_n;
   assign raw_lv[SY_PUMP]     = charge_pump_ok;
   assign raw_lv[SY_GATE_EXT] = gate_supply_external;
   assign raw_lv[SY_W +: START_W] = actuation_start_inputs;

   // Qualifier for all asynchronous levels, start pins included.
   pus_qualify #(
      .W (QW)
   ) u_qualify (
      .core_clk (core_clk),
      .rstn     (rstn),
      .raw_in   (raw_lv),
      .qual_out (lv)
   );

   // Pads only carry meaning with both their supplies up.
   assign pads_on = lv[SY_IO] & lv[SY_LOGIC];
   // An unpowered pad reads as reset asserted, the safe choice.
   assign ext_rst = pads_on & lv[SY_EXT_RST];

   // Next-state logic. Each stage falls back as soon as anything below it
   // is lost, so any supply order or ramp ends in the same ready state.
   always_comb
   begin
      st_next = st_reg;
      unique case (st_reg.stage)
         PUS_OFF:
         begin
            if (lv[SY_VCC5])
               st_next.stage = PUS_BANDGAP;
         end
         PUS_BANDGAP:
         begin
            if (!lv[SY_VCC5])
               st_next.stage = PUS_OFF;
            else if (lv[SY_BANDGAP])
               st_next.stage = PUS_DAC_REF;
         end
         PUS_DAC_REF:
         begin
            if (!lv[SY_VCC5] || !lv[SY_BANDGAP])
               st_next.stage = PUS_OFF;
            else if (lv[SY_DAC_REF])
               st_next.stage = PUS_CORE_REG;
         end
         PUS_CORE_REG:
         begin
            st_next.por_cnt = '0;
            if (!lv[SY_VCC5] || !lv[SY_BANDGAP] || !lv[SY_DAC_REF])
               st_next.stage = PUS_OFF;
            else if (lv[SY_CORE])
               st_next.stage = PUS_POR_HOLD;
         end
         PUS_POR_HOLD:
         begin
            // The core supply must stay good for the whole filter time.
            if (!lv[SY_VCC5] || !lv[SY_BANDGAP] || !lv[SY_DAC_REF])
               st_next.stage = PUS_OFF;
            else if (!lv[SY_CORE])
               st_next.stage = PUS_CORE_REG;
            else if (st_reg.por_cnt == CNT_W'(POR_FILTER_CYC - 1))
               st_next.stage = PUS_READY;
            else
               st_next.por_cnt = st_reg.por_cnt + 1'b1;
         end
         PUS_READY:
         begin
            if (!lv[SY_VCC5] || !lv[SY_BANDGAP] || !lv[SY_DAC_REF])
               st_next.stage = PUS_OFF;
            else if (!lv[SY_CORE])
               st_next.stage = PUS_CORE_REG;
         end
      endcase

      // Analog enables follow the stage reached in the next cycle.
      st_next.bg_en   = (st_next.stage != PUS_OFF);
      st_next.dac_en  = st_next.bg_en &&
                        (st_next.stage != PUS_BANDGAP);
      st_next.core_en = st_next.dac_en &&
                        (st_next.stage != PUS_DAC_REF);
      st_next.por_n   = (st_next.stage == PUS_READY);

      // Core reset is the AND of all three reset sources.
      st_next.rst_n = st_next.por_n & ext_rst & spi_reset_n;

      // Pump waits for reset release and a usable boost input.
      st_next.cp_en = st_next.por_n & lv[SY_BOOST];
      st_next.io_en = pads_on;
      // PLL runs from the input clock once pads and core are alive.
      st_next.pll = pads_on & st_next.por_n & lv[SY_CLK_IN];

      // I/O ready timer restarts whenever reset or pads drop.
      if (!st_next.por_n || !pads_on)
      begin
         st_next.dio_cnt = '0;
         st_next.io_rdy  = 1'b0;
      end
      else if (st_reg.dio_cnt == CNT_W'(DIO_READY_CYC - 1))
         st_next.io_rdy = 1'b1;
      else
         st_next.dio_cnt = st_reg.dio_cnt + 1'b1;

      // Gate regulator request is held until a core reset; the run also
      // waits for the pump and stays off with an external gate supply.
      if (!st_next.rst_n)
         st_next.gate_cmd = 1'b0;
      else if (spi_gate_reg_enable)
         st_next.gate_cmd = 1'b1;
      st_next.gate_en = st_next.gate_cmd & st_next.cp_en &
                        lv[SY_PUMP] & ~lv[SY_GATE_EXT];

      // Microcores, boost and drivers all die with the core reset.
      st_next.mc    = st_next.rst_n & microcore_enable;
      st_next.boost = st_next.mc;
      st_next.drv   = st_next.mc & st_reg.boost;
      // Starts only act once boost has been running a cycle.
      st_next.starts = (st_next.drv && pads_on) ?
                       lv[SY_W +: START_W] : '0;
   end

   // State register; everything off while the device reset is low.
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   // Outputs come straight from the state register.
   assign bandgap_en          = st_reg.bg_en;
   assign dac_reference_en    = st_reg.dac_en;
   assign core_reg_en         = st_reg.core_en;
   assign charge_pump_en      = st_reg.cp_en;
   assign pll_en              = st_reg.pll;
   assign gate_supply_reg_en  = st_reg.gate_en;
   assign boost_en            = st_reg.boost;
   assign power_on_reset_n    = st_reg.por_n;
   assign core_reset_n        = st_reg.rst_n;
   assign io_enable           = st_reg.io_en;
   assign io_ready            = st_reg.io_rdy;
   assign microcore_run       = st_reg.mc;
   assign predriver_enable    = st_reg.drv;
   assign actuation_start_out = st_reg.starts;

   // Checks on the sequencing.
   a_ref_order: assert property (@(posedge core_clk) disable iff (!rstn)
      core_reg_en |-> dac_reference_en && bandgap_en)
      else $error("Core regulator on without references.");

   a_por_filter: assert property (@(posedge core_clk) disable iff (!rstn)
      $rose(power_on_reset_n) |-> $past(lv[SY_CORE], 2))
      else $error("Reset released without good core supply.");

   a_pump_gate: assert property (@(posedge core_clk) disable iff (!rstn)
      charge_pump_en |-> power_on_reset_n)
      else $error("Charge pump on while power-on reset held.");

   a_io_pads: assert property (@(posedge core_clk) disable iff (!rstn)
      !$past(pads_on) |-> actuation_start_out == '0 && !pll_en)
      else $error("Pads used without their supplies.");

   a_pll_clock: assert property (@(posedge core_clk) disable iff (!rstn)
      pll_en |-> $past(lv[SY_CLK_IN]))
      else $error("PLL enabled without a stable input clock.");

   a_gate_pump: assert property (@(posedge core_clk) disable iff (!rstn)
      gate_supply_reg_en |-> charge_pump_en && core_reset_n)
      else $error("Gate regulator on without pump or in reset.");

   a_gate_cmd: assert property (@(posedge core_clk) disable iff (!rstn)
      $rose(gate_supply_reg_en) |-> $past(st_reg.gate_cmd) ||
         $past(spi_gate_reg_enable))
      else $error("Gate regulator on without an SPI request.");

   a_core_and: assert property (@(posedge core_clk) disable iff (!rstn)
      !spi_reset_n |=> !core_reset_n && !microcore_run)
      else $error("SPI reset did not reach core reset.");

   a_reset_off: assert property (@(posedge core_clk) disable iff (!rstn)
      !core_reset_n |-> !microcore_run && !predriver_enable &&
         !gate_supply_reg_en)
      else $error("Drive side active during core reset.");

   a_boost_first: assert property (@(posedge core_clk) disable iff (!rstn)
      actuation_start_out != '0 |-> boost_en && $past(boost_en))
      else $error("Actuation before boost converter start.");

   c_full_up: cover property (@(posedge core_clk) disable iff (!rstn)
      $rose(core_reset_n) && lv[SY_PLL]);
   c_gate_on: cover property (@(posedge core_clk) disable iff (!rstn)
      $rose(gate_supply_reg_en));
   c_actuate: cover property (@(posedge core_clk) disable iff (!rstn)
      $rose(predriver_enable) ##[1:20] actuation_start_out != '0);
   c_supply_drop: cover property (@(posedge core_clk) disable iff (!rstn)
      power_on_reset_n ##1 !power_on_reset_n);

endmodule // pus_sequencer
